// [hdl/ttc_consts.svh]
// offsets, field positions, reset values and phase counts of the timer block
`ifndef TTC_CONSTS_SVH
`define TTC_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TTC_OFF_CFG 8'h00
`define TTC_OFF_TIMER_MODE_REG 8'h04
`define TTC_OFF_TIMER_CONTROL_REG 8'h08
`define TTC_OFF_T0LO 8'h0C
`define TTC_OFF_T0HI 8'h10
`define TTC_OFF_T1LO 8'h14
`define TTC_OFF_T1HI 8'h18
`define TTC_OFF_THIRD_CONTROL_REG 8'h1C
`define TTC_OFF_T2LO 8'h20
`define TTC_OFF_T2HI 8'h24
`define TTC_OFF_CAPLO 8'h28
`define TTC_OFF_CAPHI 8'h2C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TTC_CFG_SIX 0
`define TTC_TM_MODE0 0
`define TTC_TM_CT0 2
`define TTC_TM_GATE0 3
`define TTC_TM_MODE1 4
`define TTC_TM_CT1 6
`define TTC_TM_GATE1 7
`define TTC_TC_RUN0 4
`define TTC_TC_OVF0 5
`define TTC_TC_RUN1 6
`define TTC_TC_OVF1 7
`define TTC_X_CRS 0
`define TTC_X_FSEL 1
`define TTC_X_RUN 2
`define TTC_X_EXEN 3
`define TTC_X_EXF 6
`define TTC_X_TF 7

// ----------------------------------------------------------------
// mode codes, reset values, bus answers
// ----------------------------------------------------------------
`define TTC_MODE_13BIT 2'h0
`define TTC_MODE_16BIT 2'h1
`define TTC_MODE_RELOAD 2'h2
`define TTC_MODE_SPLIT 2'h3
`define TTC_RST_BYTE 8'h00
`define TTC_RESP_OKAY 2'h0
`define TTC_RESP_DECERR 2'h3

// ----------------------------------------------------------------
// machine cycle: length in oscillator periods and phase indices
// ----------------------------------------------------------------
`define TTC_CYC_12T 4'hC
`define TTC_CYC_6T 4'h6
`define TTC_PH_UPDATE 4'h2
`define TTC_PH_SAMPLE 4'h3

`endif

// [hdl/ttc_pkg.sv]
// types shared by the timer block
`default_nettype none
package ttc_pkg;
	typedef logic [7:0] ttc_addr_type;
	typedef logic [7:0] ttc_byte_type;
	typedef logic [1:0] ttc_mode_type;
	typedef logic [1:0] ttc_resp_type;
endpackage
`default_nettype wire

// [hdl/ttc_top.sv]
// triple timer/counter with an AXI4-Lite register slave
`include "ttc_consts.svh"
`default_nettype none

// Summary of operation
// - machine cycle is 12 or 6 clocks by config; it paces counting, pin sampling and capture.
// - default machine cycle is 12 clocks, timers count clock/12.
// - count pins are sampled once per machine cycle at phase C4.
// - edge is a high sample followed by a low sample.
// - counts change at C3 of the machine cycle after edge detection.
// - function select bits 2 and 6 pick cycles or pin edges.
// - mode fields are bits 1:0 and 5:4 of the mode register.
// - count only with run set and gate clear or gate pin high.
// - mode 0 is 13 bits: high byte plus low five bits.
// - mode 0 wrap 1FFF to 0 sets the overflow flag.
// - mode 1 is 16 bits; wrap to zero sets overflow flag.
// - mode 2 low byte wraps, reloads from high byte, flags.
// - second timer in mode 3 holds its count.
// - first timer mode 3 low byte uses its own controls.
// - first timer mode 3 high byte counts cycles on second run bit.
// - then second timer runs without run bit or flag.
// - third timer counts pin edges or machine cycles by select.
// - third timer advances only while its run bit is set.
// - third timer counts 16 bits up; wrap sets its flag.
// - capture pin fall copies count and sets external flag.
module ttc_top (
	input wire logic I_CORE_CLK,
	input wire logic I_SRST,
	input wire logic I_CE,
	input wire ttc_pkg::ttc_addr_type I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output ttc_pkg::ttc_resp_type O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire ttc_pkg::ttc_addr_type I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output ttc_pkg::ttc_resp_type O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic I_COUNT_PIN_A,
	input wire logic I_COUNT_PIN_B,
	input wire logic I_GATE_PIN_A,
	input wire logic I_GATE_PIN_B,
	input wire logic I_THIRD_COUNT_PIN,
	input wire logic I_CAPTURE_PIN,
	input wire logic I_T0_FLAG_CLR,
	input wire logic I_T1_FLAG_CLR,
	output logic O_T0_OVERFLOW,
	output logic O_T1_OVERFLOW,
	output logic O_THIRD_REQ
);
	import ttc_pkg::*;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// mapped offsets, shared by the write and read decode
	function automatic logic ttc_hit(input ttc_addr_type a);
		case (a)
			`TTC_OFF_CFG, `TTC_OFF_TIMER_MODE_REG, `TTC_OFF_TIMER_CONTROL_REG, `TTC_OFF_T0LO,
			`TTC_OFF_T0HI, `TTC_OFF_T1LO, `TTC_OFF_T1HI, `TTC_OFF_THIRD_CONTROL_REG,
			`TTC_OFF_T2LO, `TTC_OFF_T2HI, `TTC_OFF_CAPLO,
			`TTC_OFF_CAPHI: ttc_hit = 1'b1;
			default: ttc_hit = 1'b0;
		endcase
	endfunction

	// one count step of a timer: {overflow, high, low}
	function automatic logic [16:0] ttc_step(input ttc_mode_type m,
		input ttc_byte_type hi, input ttc_byte_type lo);
		logic [13:0] s13;
		logic [16:0] s16;
		s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		s16 = {1'b0, hi, lo} + 17'h00001;
		case (m)
			`TTC_MODE_13BIT: ttc_step = {s13[13], s13[12:5], lo[7:5],
				s13[4:0]};
			`TTC_MODE_16BIT: ttc_step = s16;
			`TTC_MODE_RELOAD: begin
				if (lo == 8'hFF) begin
					ttc_step = {1'b1, hi, hi};
				end else begin
					ttc_step = {1'b0, hi, lo + 8'h01};
				end
			end
			default: ttc_step = {(lo == 8'hFF), hi, lo + 8'h01};
		endcase
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic six_reg;
	ttc_byte_type timer_mode_reg_reg, timer_control_reg_reg, third_control_reg_reg;
	ttc_byte_type t0_lo_reg, t0_hi_reg, t1_lo_reg, t1_hi_reg;
	ttc_byte_type t2_lo_reg, t2_hi_reg, cap_lo_reg, cap_hi_reg;
	logic [3:0] ph_reg, cyc_len;
	logic upd, smp;
	logic [3:0] pins, samp_reg, prev_reg, edge_reg;
	logic aw_got_reg, w_got_reg, wr_go;
	ttc_addr_type awaddr_reg;
	ttc_byte_type wbyte_reg, rd_byte;
	logic wstrb0_reg;
	ttc_mode_type mode0, mode1;
	logic t0_split, en0, en1, en2, hi_en, cap_go;
	logic [16:0] s0, s1;

	// ----------------------------------------------------------------
	// write channel
	// ----------------------------------------------------------------
	// readies drop while ce is low so nothing is taken while frozen
	assign O_AWREADY = I_CE & ~aw_got_reg & ~O_BVALID;
	assign O_WREADY = I_CE & ~w_got_reg & ~O_BVALID;
	assign wr_go = I_CE & aw_got_reg & w_got_reg & ~O_BVALID;

	// address and data are latched in either order, then applied
	always_ff @(posedge I_CORE_CLK) begin
		if (I_SRST) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wbyte_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			O_BVALID <= 1'b0;
			O_BRESP <= `TTC_RESP_OKAY;
		end else if (I_CE) begin
			if (I_AWVALID && O_AWREADY) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= I_AWADDR;
			end else if (wr_go) begin
				aw_got_reg <= 1'b0;
			end
			if (I_WVALID && O_WREADY) begin
				w_got_reg <= 1'b1;
				wbyte_reg <= I_WDATA[7:0];
				wstrb0_reg <= I_WSTRB[0];
			end else if (wr_go) begin
				w_got_reg <= 1'b0;
			end
			if (wr_go) begin
				O_BVALID <= 1'b1;
				O_BRESP <= ttc_hit(awaddr_reg) ? `TTC_RESP_OKAY :
					`TTC_RESP_DECERR;
			end else if (I_BREADY) begin
				O_BVALID <= 1'b0;
			end
		end
	end

	// byte lane 0 carries every register, upper lanes are ignored
	function automatic logic wr_at(input ttc_addr_type off);
		wr_at = wr_go & wstrb0_reg & (awaddr_reg == off);
	endfunction

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	assign O_ARREADY = I_CE & ~O_RVALID;

	// read mux; the flags show the live sticky state
	always_comb begin
		case (I_ARADDR)
			`TTC_OFF_CFG: rd_byte = {7'h00, six_reg};
			`TTC_OFF_TIMER_MODE_REG: rd_byte = timer_mode_reg_reg;
			`TTC_OFF_TIMER_CONTROL_REG: rd_byte = timer_control_reg_reg;
			`TTC_OFF_T0LO: rd_byte = t0_lo_reg;
			`TTC_OFF_T0HI: rd_byte = t0_hi_reg;
			`TTC_OFF_T1LO: rd_byte = t1_lo_reg;
			`TTC_OFF_T1HI: rd_byte = t1_hi_reg;
			`TTC_OFF_THIRD_CONTROL_REG: rd_byte = third_control_reg_reg;
			`TTC_OFF_T2LO: rd_byte = t2_lo_reg;
			`TTC_OFF_T2HI: rd_byte = t2_hi_reg;
			`TTC_OFF_CAPLO: rd_byte = cap_lo_reg;
			`TTC_OFF_CAPHI: rd_byte = cap_hi_reg;
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_SRST) begin
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h00000000;
			O_RRESP <= `TTC_RESP_OKAY;
		end else if (I_CE) begin
			if (I_ARVALID && O_ARREADY) begin
				O_RVALID <= 1'b1;
				O_RDATA <= {24'h000000, rd_byte};
				O_RRESP <= ttc_hit(I_ARADDR) ? `TTC_RESP_OKAY :
					`TTC_RESP_DECERR;
			end else if (I_RREADY) begin
				O_RVALID <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// machine cycle
	// ----------------------------------------------------------------
	// reset leaves the 12-clock cycle, so the count rate is clock/12
	assign cyc_len = six_reg ? `TTC_CYC_6T : `TTC_CYC_12T;
	assign upd = I_CE & (ph_reg == `TTC_PH_UPDATE);
	assign smp = I_CE & (ph_reg == `TTC_PH_SAMPLE);

	always_ff @(posedge I_CORE_CLK) begin
		if (I_SRST) begin
			six_reg <= 1'b0;
		end else if (I_CE && wr_at(`TTC_OFF_CFG)) begin
			six_reg <= wbyte_reg[`TTC_CFG_SIX];
		end
	end

	// >= guards a switch to 6T while the phase is already past 5
	always_ff @(posedge I_CORE_CLK) begin
		if (I_SRST) begin
			ph_reg <= 4'h0;
		end else if (I_CE) begin
			if (ph_reg >= cyc_len - 4'h1) begin
				ph_reg <= 4'h0;
			end else begin
				ph_reg <= ph_reg + 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// pin sampling and falling edge detection
	// ----------------------------------------------------------------
	assign pins = {I_CAPTURE_PIN, I_THIRD_COUNT_PIN, I_COUNT_PIN_B,
		I_COUNT_PIN_A};

	// sample at C4; edge is consumed at C3 of the next machine cycle
	for (genvar g = 0; g < 4; g++) begin : g_pin
		always_ff @(posedge I_CORE_CLK) begin
			if (I_SRST) begin
				samp_reg[g] <= 1'b0;
				prev_reg[g] <= 1'b0;
				edge_reg[g] <= 1'b0;
			end else if (smp) begin
				prev_reg[g] <= samp_reg[g];
				samp_reg[g] <= pins[g];
				edge_reg[g] <= samp_reg[g] & ~pins[g];
			end
		end
	end

	// ----------------------------------------------------------------
	// first and second timer
	// ----------------------------------------------------------------
	assign mode0 = timer_mode_reg_reg[`TTC_TM_MODE0 +: 2];
	assign mode1 = timer_mode_reg_reg[`TTC_TM_MODE1 +: 2];
	assign t0_split = (mode0 == `TTC_MODE_SPLIT);
	// run and gate qualify; function select picks cycles or edges
	assign en0 = timer_control_reg_reg[`TTC_TC_RUN0] & (~timer_mode_reg_reg[`TTC_TM_GATE0] |
		I_GATE_PIN_A) & (timer_mode_reg_reg[`TTC_TM_CT0] ? edge_reg[0] :
		1'b1);
	// with the first timer split, the second loses its run bit
	assign en1 = (t0_split | timer_control_reg_reg[`TTC_TC_RUN1]) &
		(mode1 != `TTC_MODE_SPLIT) & (~timer_mode_reg_reg[`TTC_TM_GATE1] |
		I_GATE_PIN_B) & (timer_mode_reg_reg[`TTC_TM_CT1] ? edge_reg[1] :
		1'b1);
	assign hi_en = t0_split & timer_control_reg_reg[`TTC_TC_RUN1];
	assign s0 = ttc_step(mode0, t0_hi_reg, t0_lo_reg);
	assign s1 = ttc_step(mode1, t1_hi_reg, t1_lo_reg);

	always_ff @(posedge I_CORE_CLK) begin
		if (I_SRST) begin
			timer_mode_reg_reg <= `TTC_RST_BYTE;
			timer_control_reg_reg <= `TTC_RST_BYTE;
			t0_lo_reg <= `TTC_RST_BYTE;
			t0_hi_reg <= `TTC_RST_BYTE;
			t1_lo_reg <= `TTC_RST_BYTE;
			t1_hi_reg <= `TTC_RST_BYTE;
		end else if (I_CE) begin
			if (wr_at(`TTC_OFF_TIMER_MODE_REG)) begin
				timer_mode_reg_reg <= wbyte_reg;
			end
			// count steps; a software write to a byte overrides it
			if (upd && en0) begin
				t0_lo_reg <= s0[7:0];
				if (!t0_split) begin
					t0_hi_reg <= s0[15:8];
				end
			end
			if (upd && hi_en) begin
				t0_hi_reg <= t0_hi_reg + 8'h01;
			end
			if (upd && en1) begin
				t1_lo_reg <= s1[7:0];
				t1_hi_reg <= s1[15:8];
			end
			if (wr_at(`TTC_OFF_T0LO)) begin
				t0_lo_reg <= wbyte_reg;
			end
			if (wr_at(`TTC_OFF_T0HI)) begin
				t0_hi_reg <= wbyte_reg;
			end
			if (wr_at(`TTC_OFF_T1LO)) begin
				t1_lo_reg <= wbyte_reg;
			end
			if (wr_at(`TTC_OFF_T1HI)) begin
				t1_hi_reg <= wbyte_reg;
			end
			// flags: write or ack clears, a same-cycle overflow wins
			timer_control_reg_reg <= wr_at(`TTC_OFF_TIMER_CONTROL_REG) ? wbyte_reg : timer_control_reg_reg;
			if (I_T0_FLAG_CLR) begin
				timer_control_reg_reg[`TTC_TC_OVF0] <= 1'b0;
			end
			if (I_T1_FLAG_CLR) begin
				timer_control_reg_reg[`TTC_TC_OVF1] <= 1'b0;
			end
			if (upd && en0 && s0[16]) begin
				timer_control_reg_reg[`TTC_TC_OVF0] <= 1'b1;
			end
			if (upd && ((hi_en && t0_hi_reg == 8'hFF) ||
				(!t0_split && en1 && s1[16]))) begin
				timer_control_reg_reg[`TTC_TC_OVF1] <= 1'b1;
			end
		end
	end

	assign O_T0_OVERFLOW = timer_control_reg_reg[`TTC_TC_OVF0];
	assign O_T1_OVERFLOW = timer_control_reg_reg[`TTC_TC_OVF1];

	// ----------------------------------------------------------------
	// third timer with capture
	// ----------------------------------------------------------------
	// timer clock is the machine cycle, clock/12 in the default mode
	assign en2 = third_control_reg_reg[`TTC_X_RUN] & (third_control_reg_reg[`TTC_X_FSEL] ?
		edge_reg[2] : 1'b1);
	assign cap_go = upd & third_control_reg_reg[`TTC_X_CRS] & third_control_reg_reg[`TTC_X_EXEN] &
		edge_reg[3];

	always_ff @(posedge I_CORE_CLK) begin
		if (I_SRST) begin
			third_control_reg_reg <= `TTC_RST_BYTE;
			t2_lo_reg <= `TTC_RST_BYTE;
			t2_hi_reg <= `TTC_RST_BYTE;
			cap_lo_reg <= `TTC_RST_BYTE;
			cap_hi_reg <= `TTC_RST_BYTE;
		end else if (I_CE) begin
			if (upd && en2) begin
				{t2_hi_reg, t2_lo_reg} <= {t2_hi_reg, t2_lo_reg} +
					16'h0001;
			end
			if (wr_at(`TTC_OFF_T2LO)) begin
				t2_lo_reg <= wbyte_reg;
			end
			if (wr_at(`TTC_OFF_T2HI)) begin
				t2_hi_reg <= wbyte_reg;
			end
			// capture keeps the count as it stood before this step
			if (cap_go) begin
				{cap_hi_reg, cap_lo_reg} <= {t2_hi_reg, t2_lo_reg};
			end
			if (wr_at(`TTC_OFF_CAPLO)) begin
				cap_lo_reg <= wbyte_reg;
			end
			if (wr_at(`TTC_OFF_CAPHI)) begin
				cap_hi_reg <= wbyte_reg;
			end
			third_control_reg_reg <= wr_at(`TTC_OFF_THIRD_CONTROL_REG) ? wbyte_reg : third_control_reg_reg;
			if (upd && en2 && {t2_hi_reg, t2_lo_reg} == 16'hFFFF) begin
				third_control_reg_reg[`TTC_X_TF] <= 1'b1;
			end
			if (cap_go) begin
				third_control_reg_reg[`TTC_X_EXF] <= 1'b1;
			end
		end
	end

	assign O_THIRD_REQ = third_control_reg_reg[`TTC_X_TF] | third_control_reg_reg[`TTC_X_EXF];

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking ck @(posedge I_CORE_CLK); endclocking
	default disable iff (I_SRST);

	chk_phase_range: assert property (
		ph_reg < cyc_len || $past(wr_at(`TTC_OFF_CFG)))
		else $error("phase beyond machine cycle");
	chk_reset_twelve: assert property (
		$past(I_SRST) |-> !six_reg && cyc_len == 4'hC)
		else $error("reset did not select 12-clock cycle");
	chk_sample_phase: assert property (
		!$past(I_SRST) && $changed(samp_reg) |->
		$past(ph_reg) == 4'h3 && $past(I_CE))
		else $error("pin sample taken off phase C4");
	chk_edge_shape: assert property (
		$rose(edge_reg[0]) |-> prev_reg[0] && !samp_reg[0])
		else $error("edge without high then low samples");
	chk_update_phase: assert property (
		!$past(I_SRST) && $changed(t1_lo_reg) |->
		$past(ph_reg) == 4'h2 || $past(wr_go))
		else $error("count moved off phase C3");
	chk_run_stops: assert property (
		!timer_control_reg_reg[`TTC_TC_RUN0] && !wr_go |=> $stable(t0_lo_reg))
		else $error("first timer counted while stopped");
	chk_t1_frozen: assert property (
		mode1 == 2'h3 && !wr_go |=> $stable({t1_hi_reg, t1_lo_reg}))
		else $error("second timer moved in mode 3");
	chk_reload_value: assert property (
		upd && en0 && mode0 == 2'h2 && t0_lo_reg == 8'hFF && !wr_go
		|=> t0_lo_reg == $past(t0_hi_reg) && timer_control_reg_reg[5])
		else $error("mode 2 reload wrong");
	chk_flag_sticky: assert property (
		timer_control_reg_reg[5] && !I_T0_FLAG_CLR && !wr_go ##1 I_CE |-> timer_control_reg_reg[5])
		else $error("overflow flag dropped by itself");
	chk_capture_copy: assert property (
		cap_go && !wr_go |=> {cap_hi_reg, cap_lo_reg} ==
		$past({t2_hi_reg, t2_lo_reg}) && third_control_reg_reg[6])
		else $error("capture did not copy count");

endmodule
`default_nettype wire

// [verif/ttc_pins.sv]
// pin-side model: count pins, gate pins and the capture pin
`default_nettype none
module ttc_pins (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [3:0] i_sel,
	input wire logic [7:0] i_num,
	input wire logic [7:0] i_hold,
	input wire logic [1:0] i_gate,
	output logic [3:0] o_pin,
	output logic [1:0] o_gate,
	output logic o_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	int left = 0;
	int cnt = 0;
	initial begin
		o_pin = 4'hF;
		o_gate = 2'h0;
		o_busy = 1'b0;
	end
	// gate levels follow the bench one clock later
	always @(posedge i_clk) o_gate <= i_gate;
	// idle high, so a burst of 2*i_num toggles gives i_num falls;
	// each level lasts i_hold+1 clocks, never under a machine cycle
	always @(posedge i_clk) begin
		if (i_go && !o_busy) begin
			o_busy <= 1'b1;
			left = 2 * i_num;
			cnt = i_hold;
		end else if (o_busy && cnt > 0) begin
			cnt--;
		end else if (o_busy && left == 0) begin
			o_busy <= 1'b0;
		end else if (o_busy) begin
			o_pin <= o_pin ^ i_sel;
			left--;
			cnt = i_hold;
		end
	end
endmodule
`default_nettype wire

// [verif/ttc_top_bench.sv]
// self-checking bench of the triple timer block
`include "ttc_consts.svh"
`default_nettype none
module ttc_top_bench;
	import ttc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic srst = 1'b1;
	ttc_addr_type awa = 8'h00;
	ttc_addr_type ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic arv = 1'b0;
	logic [1:0] clr = 2'h0;
	logic go = 1'b0;
	logic [3:0] sel = 4'h0;
	logic [7:0] num = 8'h00;
	logic [7:0] hold = 8'h0C;
	logic [1:0] gate = 2'h0;
	logic [31:0] rdat;
	ttc_resp_type br, rr;
	logic awr, wrd, arr, bv, rv, ov0, ov1, req, pbusy, f1, f2;
	logic [3:0] pin;
	logic [1:0] gp;
	int bad_count = 0;
	int checked = 0;
	int seed = 32'h3a15;
	int cyc = 0;
	int len = 12;
	// clock and free-running cycle count for timed windows
	always #2.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	ttc_top u_dut (.I_CORE_CLK(clk), .I_SRST(srst), .I_CE(1'b1),
		.I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr),
		.I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrd),
		.O_BRESP(br), .O_BVALID(bv), .I_BREADY(1'b1),
		.I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
		.O_RDATA(rdat), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(1'b1),
		.I_COUNT_PIN_A(pin[0]), .I_COUNT_PIN_B(pin[1]),
		.I_GATE_PIN_A(gp[0]), .I_GATE_PIN_B(gp[1]),
		.I_THIRD_COUNT_PIN(pin[2]), .I_CAPTURE_PIN(pin[3]),
		.I_T0_FLAG_CLR(clr[0]), .I_T1_FLAG_CLR(clr[1]),
		.O_T0_OVERFLOW(ov0), .O_T1_OVERFLOW(ov1), .O_THIRD_REQ(req));
	ttc_pins u_pins (.i_clk(clk), .i_go(go), .i_sel(sel), .i_num(num),
		.i_hold(hold), .i_gate(gate), .o_pin(pin), .o_gate(gp),
		.o_busy(pbusy));
	// ----------------------------------------------------------------
	// reporting, bus cycles and the reference model
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_resp(input ttc_resp_type got, input ttc_resp_type exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t resp got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one clock edge; a wait that runs too long ends the run
	task automatic tick(inout int n);
		@(posedge clk);
		n++;
		if (n > 1000) begin
			bad_count++;
			close_out();
		end
	endtask
	task automatic wr(input logic [7:0] a, input int d, output ttc_resp_type r);
		int n;
		logic pa, pw;
		n = 0;
		pa = 1'b1;
		pw = 1'b1;
		awa <= a;
		wd <= 32'(d & 255);
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			tick(n);
			if (pa && awr) begin
				pa = 1'b0;
				awv <= 1'b0;
			end
			if (pw && wrd) begin
				pw = 1'b0;
				wv <= 1'b0;
			end
		end while (!bv);
		r = br;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d,
		output ttc_resp_type r);
		int n;
		n = 0;
		ara <= a;
		arv <= 1'b1;
		do begin
			tick(n);
			if (arr) arv <= 1'b0;
		end while (!rv);
		d = rdat[15:0];
		r = rr;
	endtask
	task automatic chk(input logic [7:0] a, input int e);
		logic [15:0] d;
		ttc_resp_type r;
		rd(a, d, r);
		cmp(d, 16'(e));
	endtask
	// exact window: on and off writes taken len*k clocks apart
	task automatic win(input logic [7:0] a, input int on, input int off,
		input int k);
		int t;
		ttc_resp_type r;
		t = cyc + 2;
		while (cyc < t) @(posedge clk);
		wr(a, on, r);
		while (cyc < t + len * k) @(posedge clk);
		f1 = ov1;
		f2 = req;
		wr(a, off, r);
	endtask
	// bursts of falls from the pin model, then let the count settle
	task automatic pulse(input logic [3:0] s, input int n);
		int c;
		c = 0;
		sel <= s;
		num <= 8'(n);
		hold <= 8'(12 + ($random(seed) & 7));
		go <= 1'b1;
		tick(c);
		go <= 1'b0;
		do tick(c); while (pbusy);
		repeat (3 * len) @(posedge clk);
	endtask
	// k increments of a timer in mode m, result {flag, high, low}
	function automatic logic [16:0] step(input int m, input int hi,
		input int lo, input int k);
		int v, f;
		f = 0;
		for (int i = 0; i < k; i++) begin
			if (m == 0) begin
				v = ((hi << 5) | (lo & 31)) + 1;
				f = f | (v >> 13);
				hi = (v >> 5) & 255;
				lo = (lo & 224) | (v & 31);
			end else if (m == 1) begin
				v = (hi << 8) + lo + 1;
				f = f | (v >> 16);
				hi = (v >> 8) & 255;
				lo = v & 255;
			end else begin
				lo = lo + 1;
				f = f | (lo >> 8);
				lo = (lo > 255) ? hi : lo;
			end
		end
		return {f[0], 8'(hi), 8'(lo)};
	endfunction
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] d;
		logic [16:0] ex;
		ttc_resp_type r;
		int lo, hi, k, m, x, n, mk;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		for (int a = 0; a < 12; a++) begin
			rd(8'(a * 4), d, r);
			cmp(d, 16'h0000);
			cmp_resp(r, `TTC_RESP_OKAY);
		end
		rd(8'h30, d, r);
		cmp_resp(r, `TTC_RESP_DECERR);
		wr(8'h30, 8'h5A, r);
		cmp_resp(r, `TTC_RESP_DECERR);
		// modes 0 to 2 of both timers, 12- and 6-clock machine cycles
		for (int c = 0; c < 2; c++) begin
			len = c ? 6 : 12;
			wr(`TTC_OFF_CFG, c, r);
			for (x = 0; x < 2; x++) begin
				for (m = 0; m < 3; m++) begin
					// mode 2 starts near FFh so every window wraps and reloads
					lo = (m == 2) ? (253 | ($random(seed) & 2)) :
						($random(seed) & 255);
					hi = ($random(seed) & 1) ? 255 : ($random(seed) & 255);
					k = 3 + ($random(seed) & 15);
					mk = (m == 0) ? 31 : 255;
					wr(8'h0C + 8'(x * 8), lo, r);
					wr(8'h10 + 8'(x * 8), hi, r);
					// gate the timer off first, so the run bit alone cannot count
					wr(`TTC_OFF_TIMER_MODE_REG, (m + 8) << (4 * x), r);
					wr(`TTC_OFF_TIMER_CONTROL_REG, 16 << (2 * x), r);
					win(`TTC_OFF_TIMER_MODE_REG, m << (4 * x), (m + 8) << (4 * x), k);
					ex = step(m, hi, lo, k);
					rd(8'h0C + 8'(x * 8), d, r);
					cmp(d & 16'(mk), 16'(ex[7:0] & mk));
					chk(8'h10 + 8'(x * 8), ex[15:8]);
					chk(`TTC_OFF_TIMER_CONTROL_REG, (16 | (ex[16] << 5)) << (2 * x));
					cmp(x ? ov1 : ov0, ex[16]);
					clr <= 2'(1 << x);
					@(posedge clk);
					clr <= 2'h0;
					repeat (2) @(posedge clk);
					cmp(x ? ov1 : ov0, 1'b0);
				end
			end
		end
		// pin counting, held off by a low gate pin
		for (x = 0; x < 2; x++) begin
			n = 1 + ($random(seed) & 7);
			wr(`TTC_OFF_TIMER_MODE_REG, 13 << (4 * x), r);
			wr(8'h0C + 8'(x * 8), 0, r);
			wr(`TTC_OFF_TIMER_CONTROL_REG, 16 << (2 * x), r);
			pulse(4'(1 << x), n);
			chk(8'h0C + 8'(x * 8), 0);
			gate <= 2'(1 << x);
			pulse(4'(1 << x), n);
			chk(8'h0C + 8'(x * 8), n);
			gate <= 2'h0;
		end
		// first timer split into two bytes, then second timer frozen
		lo = $random(seed) & 255;
		k = 3 + ($random(seed) & 15);
		wr(`TTC_OFF_T0LO, lo, r);
		wr(`TTC_OFF_T0HI, 255, r);
		// run1 still set here would start the high byte before the window
		wr(`TTC_OFF_TIMER_CONTROL_REG, 0, r);
		wr(`TTC_OFF_TIMER_MODE_REG, 3, r);
		win(`TTC_OFF_TIMER_CONTROL_REG, 8'h50, 0, k);
		chk(`TTC_OFF_T0LO, (lo + k) & 255);
		chk(`TTC_OFF_T0HI, k - 1);
		cmp(f1, 1'b1);
		wr(`TTC_OFF_TIMER_MODE_REG, 8'h33, r);
		wr(`TTC_OFF_TIMER_CONTROL_REG, 8'h40, r);
		wr(`TTC_OFF_T1LO, lo, r);
		repeat (5 * len) @(posedge clk);
		chk(`TTC_OFF_T1LO, lo);
		// third timer: cycles, pin edges, capture off and on
		lo = 254 | ($random(seed) & 1);
		k = 3 + ($random(seed) & 15);
		wr(`TTC_OFF_T2LO, lo, r);
		wr(`TTC_OFF_T2HI, 255, r);
		win(`TTC_OFF_THIRD_CONTROL_REG, 5, 1, k);
		ex = step(1, 255, lo, k);
		chk(`TTC_OFF_T2LO, ex[7:0]);
		chk(`TTC_OFF_T2HI, ex[15:8]);
		cmp(f2, 1'b1);
		n = 1 + ($random(seed) & 7);
		wr(`TTC_OFF_T2LO, 0, r);
		wr(`TTC_OFF_T2HI, 0, r);
		wr(`TTC_OFF_THIRD_CONTROL_REG, 7, r);
		pulse(4'b0100, n);
		wr(`TTC_OFF_THIRD_CONTROL_REG, 1, r);
		chk(`TTC_OFF_T2LO, n);
		pulse(4'b1000, 1);
		chk(`TTC_OFF_CAPLO, 0);
		cmp(req, 1'b0);
		wr(`TTC_OFF_THIRD_CONTROL_REG, 9, r);
		pulse(4'b1000, 1);
		pulse(4'b1000, 1);
		chk(`TTC_OFF_CAPLO, n);
		chk(`TTC_OFF_THIRD_CONTROL_REG, 8'h49);
		cmp(req, 1'b1);
		close_out();
	end
endmodule
`default_nettype wire
